/* verilog/eim_pkg.sv */
package eim_pkg;
    localparam int          EIM_AW          = 4;
    localparam int          EIM_DW          = 8;
    localparam int          EIM_NSRC        = 4;

    // register offsets
    localparam logic [3:0]  EIM_OFF_EN      = 4'h0;
    localparam logic [3:0]  EIM_OFF_STAT    = 4'h1;
    localparam logic [3:0]  EIM_OFF_CLR     = 4'h2;
    localparam logic [3:0]  EIM_OFF_ACTV    = 4'h3;

    // bit positions inside every register
    localparam int          EIM_B_WINDOW    = 0;
    localparam int          EIM_B_CONV      = 1;
    localparam int          EIM_B_COUNTER   = 2;
    localparam int          EIM_B_CMPFALL   = 3;

    // reset values
    localparam logic [3:0]  EIM_EN_RST      = 4'h0;
    localparam logic [3:0]  EIM_PEND_RST    = 4'h0;
    localparam logic [7:0]  EIM_RDATA_RST   = 8'h00;

    typedef struct packed {
        logic [3:0] en;
        logic [3:0] pend;
        logic [7:0] rdata;
    } eim_state_s;
endpackage

/* verilog/eim_irq_mask.sv */
// Contract
// - The comparator falling-edge enable bit (bit 3) blocks that request at 0 and passes it at 1.
// - The counter-array enable bit (bit 2) masks all counter-array requests at 0 and passes them at 1.
// - The conversion-complete enable bit (bit 1) passes conversion-done requests at 1 and suppresses them at 0.
// - The window-comparison enable bit (bit 0) suppresses that request at 0 and passes it at 1.
//
// Chosen here: strobed register access and the register addresses.
module eim_irq_mask
    import eim_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic [EIM_AW-1:0]    addr,
    input  wire logic [EIM_DW-1:0]    wdata,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic      [EIM_DW-1:0]    rdata,
    input  wire logic                 cmp_fall_evt,
    input  wire logic                 counter_array_evt,
    input  wire logic                 conv_done_flag,
    input  wire logic                 window_cmp_evt,
    output logic                      cmp_fall_irq,
    output logic                      counter_array_irq,
    output logic                      conv_done_irq,
    output logic                      window_cmp_irq,
    output logic                      irq
);

    eim_state_s          st_r;
    eim_state_s          st_nxt;
    logic [EIM_NSRC-1:0] evt;
    logic [EIM_NSRC-1:0] gated;

    function automatic logic hit(input logic [EIM_AW-1:0] a, input logic [3:0] off);
        hit = (a == EIM_AW'(off));
    endfunction

    assign evt[EIM_B_CMPFALL] = cmp_fall_evt;
    assign evt[EIM_B_COUNTER] = counter_array_evt;
    assign evt[EIM_B_CONV]    = conv_done_flag;
    assign evt[EIM_B_WINDOW]  = window_cmp_evt;

    // each source path is a plain and of its pending flag and its enable bit
    genvar g;
    generate
        for (g = 0; g < EIM_NSRC; g++) begin : g_gate
            assign gated[g] = st_r.pend[g] & st_r.en[g];
        end
    endgenerate

    assign cmp_fall_irq      = gated[EIM_B_CMPFALL];
    assign counter_array_irq = gated[EIM_B_COUNTER];
    assign conv_done_irq     = gated[EIM_B_CONV];
    assign window_cmp_irq    = gated[EIM_B_WINDOW];
    assign irq               = |gated;
    assign rdata             = st_r.rdata;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = EIM_RDATA_RST;
        if (wr_stb && hit(addr, EIM_OFF_EN)) begin
            st_nxt.en = wdata[EIM_NSRC-1:0];
        end
        // pending flags are untouched by enable writes; a new event wins over a clear
        if (wr_stb && hit(addr, EIM_OFF_CLR)) begin
            st_nxt.pend = st_r.pend & ~wdata[EIM_NSRC-1:0];
        end
        st_nxt.pend = st_nxt.pend | evt;
        if (rd_stb) begin
            if (hit(addr, EIM_OFF_EN)) begin
                st_nxt.rdata = {{(EIM_DW-EIM_NSRC){1'b0}}, st_r.en};
            end else if (hit(addr, EIM_OFF_STAT)) begin
                st_nxt.rdata = {{(EIM_DW-EIM_NSRC){1'b0}}, st_r.pend};
            end else if (hit(addr, EIM_OFF_ACTV)) begin
                st_nxt.rdata = {{(EIM_DW-EIM_NSRC){1'b0}}, gated};
            end else begin
                st_nxt.rdata = EIM_RDATA_RST;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r.en    <= EIM_EN_RST;
            st_r.pend  <= EIM_PEND_RST;
            st_r.rdata <= EIM_RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    cmp_fall_gate_a: assert property (
        cmp_fall_irq == (st_r.pend[EIM_B_CMPFALL] && st_r.en[EIM_B_CMPFALL]))
        else $error("comparator falling request not gated by its enable");

    counter_gate_a: assert property (
        !st_r.en[EIM_B_COUNTER] |-> !counter_array_irq)
        else $error("counter array request passed while disabled");

    conv_done_pass_a: assert property (
        $past(conv_done_flag) && st_r.en[EIM_B_CONV] |-> conv_done_irq)
        else $error("conversion done request lost while enabled");

    window_gate_a: assert property (
        window_cmp_irq |-> st_r.en[EIM_B_WINDOW] && st_r.pend[EIM_B_WINDOW])
        else $error("window request passed without enable and pending");

    pend_kept_a: assert property (
        $past(st_r.pend[EIM_B_CMPFALL]) && !$past(wr_stb && hit(addr, EIM_OFF_CLR))
        |-> st_r.pend[EIM_B_CMPFALL])
        else $error("pending flag lost without a clear");

    unmask_raise_a: assert property (
        st_r.pend[EIM_B_COUNTER] && !st_r.en[EIM_B_COUNTER]
        ##1 $rose(st_r.en[EIM_B_COUNTER]) |-> counter_array_irq)
        else $error("re-enable did not raise held request");

    set_over_clr_a: assert property (
        evt[EIM_B_CONV] && wr_stb && hit(addr, EIM_OFF_CLR) |=> st_r.pend[EIM_B_CONV])
        else $error("event lost in clearing cycle");

    irq_or_a: assert property (
        irq == |(st_r.pend & st_r.en))
        else $error("interrupt output disagrees with enabled pending bits");

    read_stat_a: assert property (
        rd_stb && hit(addr, EIM_OFF_STAT) |=> rdata == {4'h0, $past(st_r.pend)})
        else $error("status read returned wrong data");

    masked_held_c: cover property (
        st_r.pend[EIM_B_CMPFALL] && !st_r.en[EIM_B_CMPFALL] ##[1:20] cmp_fall_irq);
    all_four_c: cover property (
        cmp_fall_irq && counter_array_irq && conv_done_irq && window_cmp_irq);
    clear_drop_c: cover property (
        irq ##1 wr_stb && hit(addr, EIM_OFF_CLR) ##1 !irq);
endmodule

/* testbench/eim_src.sv */
module eim_src (
    input  wire logic       ref_clk,
    input  wire logic [3:0] fire,
    output logic      [3:0] evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // each request is copied to evt one ref_clk cycle later, held high for as many cycles as fire is
    always_ff @(posedge ref_clk) begin
        evt <= fire;
    end
endmodule

/* testbench/extended_irq_enable_mask_tb.sv */
module extended_irq_enable_mask_tb;
    import eim_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, irq;
    logic [3:0] addr = 4'h0, fire = 4'h0, evt, gated;
    logic [7:0] wdata = 8'h00, rdata, got;
    int         fail_count = 0, samples_checked = 0;
    always #10 ref_clk = ~ref_clk;
    eim_src src (.ref_clk(ref_clk), .fire(fire), .evt(evt));
    eim_irq_mask dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .cmp_fall_evt(evt[3]), .counter_array_evt(evt[2]),
        .conv_done_flag(evt[1]), .window_cmp_evt(evt[0]), .cmp_fall_irq(gated[3]),
        .counter_array_irq(gated[2]), .conv_done_irq(gated[1]), .window_cmp_irq(gated[0]), .irq(irq));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic outs(input logic [3:0] exp);
        chk("gated", {4'h0, exp}, {4'h0, gated});
        chk("irq", {7'h00, |exp}, {7'h00, irq});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {wr_stb, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input string what, input logic [7:0] exp);
        @(posedge ref_clk);
        {rd_stb, addr} <= {1'b1, a};
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic close_out;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #20us;
        fail_count++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(EIM_OFF_EN, "enable", 8'h00);
        rd(4'hf, "unmapped", 8'h00);
        for (int i = 0; i < EIM_NSRC; i++) begin
            @(posedge ref_clk);
            fire <= 4'h1 << i;
            @(posedge ref_clk);
            fire <= 4'h0;
            repeat (2) @(posedge ref_clk);
            #1;
            outs(4'h0);
            rd(EIM_OFF_STAT, "pending", 8'h01 << i);
            wr(EIM_OFF_EN, 8'h01 << i);
            outs(4'h1 << i);
            rd(EIM_OFF_ACTV, "active", 8'h01 << i);
            wr(EIM_OFF_EN, 8'h00);
            outs(4'h0);
            rd(EIM_OFF_STAT, "held", 8'h01 << i);
            wr(EIM_OFF_CLR, 8'h01 << i);
            wr(EIM_OFF_EN, 8'h0f);
            outs(4'h0);
            wr(EIM_OFF_EN, 8'h00);
        end
        // a conversion event landing in the same cycle as its clear must stay pending
        @(posedge ref_clk);
        fire <= 4'h2;
        @(posedge ref_clk);
        fire <= 4'h0;
        {wr_stb, addr, wdata} <= {1'b1, EIM_OFF_CLR, 8'h02};
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        #1;
        rd(EIM_OFF_STAT, "set over clear", 8'h02);
        wr(EIM_OFF_EN, 8'h02);
        outs(4'h2);
        close_out;
    end
endmodule
